//--- logic/afr_cfg_if.sv
// routing fields carried from the register file to the pin multiplexer
`timescale 1ns/100ps
interface afr_cfg_if;
	logic [1:0] clockOutSel;
	logic fastDrive;
	logic [1:0] timer0Sel;
	logic serial0Sel;
	logic [1:0] twoWireSel;
	modport regs (output clockOutSel, output fastDrive, output timer0Sel, output serial0Sel,
		output twoWireSel);
	modport mux (input clockOutSel, input fastDrive, input timer0Sel, input serial0Sel,
		input twoWireSel);
endinterface

//--- logic/afr_clock_divider.sv
// master clock copies at divide by 1, 2 and 4, built from the sampled clock level
`timescale 1ns/100ps
module afr_clock_divider (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic masterClock,
	output logic div1,
	output logic div2,
	output logic div4
);
	logic rise;

	// the master clock is sampled, so it must run below half of sys_clk
	assign rise = masterClock && !div1;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			div1 <= 1'b0;
		else
			div1 <= masterClock;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			div2 <= 1'b0;
		else if (rise)
			div2 <= !div2;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			div4 <= 1'b0;
		else if (rise && div2)
			div4 <= !div4;
	end
endmodule

//--- logic/afr_pkg.sv
// shared constants of the alternate function redirect block
package afr_pkg;
	localparam int PIN_COUNT = 40;
	localparam logic [7:0] ADDR_CLOCK_PIN_CONFIG = 8'hA1;
	localparam logic [7:0] ADDR_PORT_ROUTE_SELECT = 8'hA4;
	localparam logic [3:0] PAGE_PORT_ROUTE_SELECT = 4'h0;
	localparam logic [7:0] RESET_CLOCK_PIN_CONFIG = 8'h00;
	localparam logic [7:0] RESET_PORT_ROUTE_SELECT = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// field positions
	localparam int CLOCK_OUT_SEL_LSB = 6;
	localparam int FAST_DRIVE_BIT = 5;
	localparam int TIMER0_SEL_LSB = 6;
	localparam int SERIAL0_SEL_BIT = 3;
	localparam int TWO_WIRE_SEL_LSB = 1;
	// clock-out codes
	localparam logic [1:0] CLOCK_OUT_GPIO = 2'h0;
	localparam logic [1:0] CLOCK_OUT_DIV1 = 2'h1;
	localparam logic [1:0] CLOCK_OUT_DIV2 = 2'h2;
	localparam logic [1:0] CLOCK_OUT_DIV4 = 2'h3;
	// system clock source codes
	localparam logic [1:0] CLK_SRC_HIGH_RC = 2'h0;
	localparam logic [1:0] CLK_SRC_LOW_RC = 2'h1;
	localparam logic [1:0] CLK_SRC_CRYSTAL = 2'h2;
	localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h3;
	// flat pin index: port 0,2,3,4,6 occupy groups 0..4 of eight bits
	localparam logic [5:0] PIN_P0_5 = 6'h05;
	localparam logic [5:0] PIN_P2_2 = 6'h0A;
	localparam logic [5:0] PIN_P2_4 = 6'h0C;
	localparam logic [5:0] PIN_P3_0 = 6'h10;
	localparam logic [5:0] PIN_P3_1 = 6'h11;
	localparam logic [5:0] PIN_P3_4 = 6'h14;
	localparam logic [5:0] PIN_P4_0 = 6'h18;
	localparam logic [5:0] PIN_P4_1 = 6'h19;
	localparam logic [5:0] PIN_P4_4 = 6'h1C;
	localparam logic [5:0] PIN_P4_5 = 6'h1D;
	localparam logic [5:0] PIN_P4_6 = 6'h1E;
	localparam logic [5:0] PIN_P6_0 = 6'h20;
	localparam logic [5:0] PIN_P6_1 = 6'h21;
endpackage

//--- logic/afr_sfr_regs.sv
// the two routing registers on the special-function-register bus
`timescale 1ns/100ps
module afr_sfr_regs (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic [3:0] sfrPage,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	afr_cfg_if.regs cfg
);
	logic [7:0] clockPinConfig;
	logic [7:0] portRouteSelect;
	logic routeHit;

	// the route register lives on page 0 only; the clock register on every page
	assign routeHit = (sfrAddr == afr_pkg::ADDR_PORT_ROUTE_SELECT)
		&& (sfrPage == afr_pkg::PAGE_PORT_ROUTE_SELECT);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			clockPinConfig <= afr_pkg::RESET_CLOCK_PIN_CONFIG;
		else if (sfrWrite && sfrAddr == afr_pkg::ADDR_CLOCK_PIN_CONFIG)
			clockPinConfig <= sfrWdata;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			portRouteSelect <= afr_pkg::RESET_PORT_ROUTE_SELECT;
		else if (sfrWrite && routeHit)
			portRouteSelect <= sfrWdata;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			sfrRdata <= afr_pkg::READ_UNMAPPED;
		else if (sfrAddr == afr_pkg::ADDR_CLOCK_PIN_CONFIG)
			sfrRdata <= clockPinConfig;
		else if (routeHit)
			sfrRdata <= portRouteSelect;
		else
			sfrRdata <= afr_pkg::READ_UNMAPPED;
	end

	assign cfg.clockOutSel = clockPinConfig[afr_pkg::CLOCK_OUT_SEL_LSB +: 2];
	assign cfg.fastDrive = clockPinConfig[afr_pkg::FAST_DRIVE_BIT];
	assign cfg.timer0Sel = portRouteSelect[afr_pkg::TIMER0_SEL_LSB +: 2];
	assign cfg.serial0Sel = portRouteSelect[afr_pkg::SERIAL0_SEL_BIT];
	assign cfg.twoWireSel = portRouteSelect[afr_pkg::TWO_WIRE_SEL_LSB +: 2];
endmodule

//--- logic/alternate_function_redirect.sv
// pin multiplexer routing timer 0, serial 0, two-wire and the clock output to port pads
// Contract
// - clock-out field acts only when an internal rc oscillator clocks the system.
// - crystal mode gives p6.0/p6.1 to crystal; external clock mode uses p6.0 input.
// - clock-out codes: 00 gpio, 01 master clock, 10 divided by 2, 11 by 4.
// - any nonzero clock-out code drives the rc derived clock on p6.0.
// - clock register bit 5 selects fast drive on p6.0.
// - timer 0 pins: 00 p3.4, 01 p4.4, 10 p4.6, 11 p0.5.
// - serial 0 pins: 0 gives p3.0/p3.1, 1 gives p4.4/p4.5.
// - two-wire pins: 00 p4.0/p4.1, 01 p6.0/p6.1, 10 p3.1/p3.0, 11 p2.2/p2.4.
// - routing registers reset to zero so functions sit on default pins.
// - routing changes only on register writes; route register on page 0 only.
// - shared reset pin acts as active-high external reset input.
`timescale 1ns/100ps
module alternate_function_redirect (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] sfrAddr,
	input wire logic [3:0] sfrPage,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	input wire logic [1:0] clockSource,
	input wire logic masterClock,
	input wire logic pin6_0_output_mode_bit,
	output logic pin6_0_pushPull,
	output logic pin6_0_fast_drive,
	output logic crystal_output,
	output logic crystal_input,
	output logic external_clock_input,
	input wire logic resetPinIn,
	output logic externalResetReq,
	input wire logic [afr_pkg::PIN_COUNT-1:0] gpioOut,
	input wire logic [afr_pkg::PIN_COUNT-1:0] gpioOe,
	input wire logic [afr_pkg::PIN_COUNT-1:0] padIn,
	output logic [afr_pkg::PIN_COUNT-1:0] padOut,
	output logic [afr_pkg::PIN_COUNT-1:0] padOe,
	output logic timer0Input,
	input wire logic timer0_clock_out,
	input wire logic timer0ClockOutEn,
	output logic uart0_receive_pin,
	input wire logic uart0_transmit_pin,
	input wire logic uart0TransmitEn,
	output logic twoWireClockIn,
	input wire logic twoWireClockOut,
	input wire logic twoWireClockOe,
	output logic twoWireDataIn,
	input wire logic twoWireDataOut,
	input wire logic twoWireDataOe
);
	logic rstMeta_n;
	logic rst_n;
	logic div1;
	logic div2;
	logic div4;
	logic internalOsc;
	logic clockOutOn;
	logic clockOutLevel;
	logic [5:0] timer0Pin;
	logic [5:0] rxPin;
	logic [5:0] txPin;
	logic [5:0] twClockPin;
	logic [5:0] twDataPin;
	logic [afr_pkg::PIN_COUNT-1:0] next_padOut;
	logic [afr_pkg::PIN_COUNT-1:0] next_padOe;

	afr_cfg_if cfg ();

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstMeta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rstMeta_n <= 1'b1;
			rst_n <= rstMeta_n;
		end
	end

	afr_sfr_regs u_regs (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.sfrAddr(sfrAddr),
		.sfrPage(sfrPage),
		.sfrWrite(sfrWrite),
		.sfrWdata(sfrWdata),
		.sfrRdata(sfrRdata),
		.cfg(cfg.regs)
	);

	afr_clock_divider u_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.masterClock(masterClock),
		.div1(div1),
		.div2(div2),
		.div4(div4)
	);

	assign internalOsc = (clockSource == afr_pkg::CLK_SRC_HIGH_RC)
		|| (clockSource == afr_pkg::CLK_SRC_LOW_RC);
	assign clockOutOn = internalOsc && (cfg.clockOutSel != afr_pkg::CLOCK_OUT_GPIO);

	always_comb
	begin
		case (cfg.clockOutSel)
			afr_pkg::CLOCK_OUT_DIV1: clockOutLevel = div1;
			afr_pkg::CLOCK_OUT_DIV2: clockOutLevel = div2;
			afr_pkg::CLOCK_OUT_DIV4: clockOutLevel = div4;
			default: clockOutLevel = 1'b0;
		endcase
	end

	always_comb
	begin
		case (cfg.timer0Sel)
			2'h0: timer0Pin = afr_pkg::PIN_P3_4;
			2'h1: timer0Pin = afr_pkg::PIN_P4_4;
			2'h2: timer0Pin = afr_pkg::PIN_P4_6;
			default: timer0Pin = afr_pkg::PIN_P0_5;
		endcase
	end

	assign rxPin = cfg.serial0Sel ? afr_pkg::PIN_P4_4 : afr_pkg::PIN_P3_0;
	assign txPin = cfg.serial0Sel ? afr_pkg::PIN_P4_5 : afr_pkg::PIN_P3_1;

	always_comb
	begin
		case (cfg.twoWireSel)
			2'h0:
			begin
				twClockPin = afr_pkg::PIN_P4_0;
				twDataPin = afr_pkg::PIN_P4_1;
			end
			2'h1:
			begin
				twClockPin = afr_pkg::PIN_P6_0;
				twDataPin = afr_pkg::PIN_P6_1;
			end
			2'h2:
			begin
				twClockPin = afr_pkg::PIN_P3_1;
				twDataPin = afr_pkg::PIN_P3_0;
			end
			default:
			begin
				twClockPin = afr_pkg::PIN_P2_2;
				twDataPin = afr_pkg::PIN_P2_4;
			end
		endcase
	end

	// later overrides win: timer, serial, two-wire, clock out, then oscillator pins
	always_comb
	begin
		next_padOut = gpioOut;
		next_padOe = gpioOe;
		if (timer0ClockOutEn)
		begin
			next_padOut[timer0Pin] = timer0_clock_out;
			next_padOe[timer0Pin] = 1'b1;
		end
		if (uart0TransmitEn)
		begin
			next_padOut[txPin] = uart0_transmit_pin;
			next_padOe[txPin] = 1'b1;
		end
		next_padOut[twClockPin] = twoWireClockOut;
		next_padOe[twClockPin] = twoWireClockOe;
		next_padOut[twDataPin] = twoWireDataOut;
		next_padOe[twDataPin] = twoWireDataOe;
		if (clockOutOn)
		begin
			next_padOut[afr_pkg::PIN_P6_0] = clockOutLevel;
			next_padOe[afr_pkg::PIN_P6_0] = 1'b1;
		end
		if (clockSource == afr_pkg::CLK_SRC_CRYSTAL)
		begin
			next_padOe[afr_pkg::PIN_P6_0] = 1'b0;
			next_padOe[afr_pkg::PIN_P6_1] = 1'b0;
		end
		if (clockSource == afr_pkg::CLK_SRC_EXTERNAL)
			next_padOe[afr_pkg::PIN_P6_0] = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			padOut <= '0;
			padOe <= '0;
		end
		else
		begin
			padOut <= next_padOut;
			padOe <= next_padOe;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer0Input <= 1'b0;
			uart0_receive_pin <= 1'b1;
			twoWireClockIn <= 1'b1;
			twoWireDataIn <= 1'b1;
		end
		else
		begin
			timer0Input <= padIn[timer0Pin];
			uart0_receive_pin <= padIn[rxPin];
			twoWireClockIn <= padIn[twClockPin];
			twoWireDataIn <= padIn[twDataPin];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			crystal_output <= 1'b0;
			crystal_input <= 1'b0;
			external_clock_input <= 1'b0;
		end
		else
		begin
			crystal_output <= (clockSource == afr_pkg::CLK_SRC_CRYSTAL);
			crystal_input <= (clockSource == afr_pkg::CLK_SRC_CRYSTAL)
				&& padIn[afr_pkg::PIN_P6_1];
			external_clock_input <= (clockSource == afr_pkg::CLK_SRC_EXTERNAL)
				&& padIn[afr_pkg::PIN_P6_0];
		end
	end

	// output mode stays software's; the block only forwards the mode bit
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin6_0_pushPull <= 1'b0;
			pin6_0_fast_drive <= 1'b0;
			externalResetReq <= 1'b0;
		end
		else
		begin
			pin6_0_pushPull <= pin6_0_output_mode_bit;
			pin6_0_fast_drive <= cfg.fastDrive;
			externalResetReq <= resetPinIn;
		end
	end

	sequence seqClockWrite;
		sfrWrite && sfrAddr == afr_pkg::ADDR_CLOCK_PIN_CONFIG;
	endsequence

	sequence seqDiv1Selected;
		cfg.clockOutSel == afr_pkg::CLOCK_OUT_DIV1 && internalOsc;
	endsequence

	AST_CLOCK_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clockSource == afr_pkg::CLK_SRC_EXTERNAL |=> !padOe[afr_pkg::PIN_P6_0])
		else $error("p6.0 driven while external clock selected");
	AST_CRYSTAL_PINS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clockSource == afr_pkg::CLK_SRC_CRYSTAL
		|=> !padOe[afr_pkg::PIN_P6_0] && !padOe[afr_pkg::PIN_P6_1] && crystal_output)
		else $error("crystal pins not released");
	AST_DIV1_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seqDiv1Selected |=> padOe[afr_pkg::PIN_P6_0] && padOut[afr_pkg::PIN_P6_0] == $past(div1))
		else $error("master clock missing on p6.0");
	AST_GPIO_P60: assert property (@(posedge sys_clk) disable iff (!rst_n)
		internalOsc && cfg.clockOutSel == afr_pkg::CLOCK_OUT_GPIO && cfg.twoWireSel != 2'h1
		|=> padOut[afr_pkg::PIN_P6_0] == $past(gpioOut[afr_pkg::PIN_P6_0]))
		else $error("p6.0 not plain port");
	// a second write right behind the first would move the bit again, so it is excluded
	AST_FAST_DRIVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seqClockWrite ##1 !(sfrWrite && sfrAddr == afr_pkg::ADDR_CLOCK_PIN_CONFIG)
		|=> pin6_0_fast_drive == $past(sfrWdata[afr_pkg::FAST_DRIVE_BIT], 2))
		else $error("fast drive not following register");
	AST_TIMER0_P05: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.timer0Sel == 2'h3 && timer0ClockOutEn |=> padOe[afr_pkg::PIN_P0_5]
		&& padOut[afr_pkg::PIN_P0_5] == $past(timer0_clock_out))
		else $error("timer 0 not on p0.5");
	AST_SERIAL_RX: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.serial0Sel |=> uart0_receive_pin == $past(padIn[afr_pkg::PIN_P4_4]))
		else $error("receive not from p4.4");
	AST_TWO_WIRE_P24: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.twoWireSel == 2'h3 |=> padOe[afr_pkg::PIN_P2_4] == $past(twoWireDataOe))
		else $error("two-wire data not on p2.4");
	AST_RESET_ZERO: assert property (@(posedge sys_clk)
		$rose(rst_n) |-> cfg.timer0Sel == 2'h0 && cfg.clockOutSel == 2'h0 && !cfg.serial0Sel)
		else $error("routing not zero after reset");
	AST_PAGE_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sfrWrite && sfrPage != afr_pkg::PAGE_PORT_ROUTE_SELECT
		&& !(sfrWrite && sfrAddr == afr_pkg::ADDR_PORT_ROUTE_SELECT && sfrPage == 4'h0)
		|=> $stable(cfg.timer0Sel))
		else $error("route changed from another page");
	AST_RESET_PIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		resetPinIn [*2] |=> externalResetReq)
		else $error("reset pin not forwarded");
	AST_MOVED_PIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg.timer0Sel == 2'h1 && cfg.serial0Sel == 1'b0 && cfg.twoWireSel == 2'h0
		|=> padOe[afr_pkg::PIN_P3_4] == $past(gpioOe[afr_pkg::PIN_P3_4]))
		else $error("p3.4 kept by moved timer");
endmodule

//--- verification/afr_board_model.sv
// board side of the pads: a pad reads what drives it, else the board, else the pull-up
`timescale 1ns/100ps
module afr_board_model (
	input wire logic [afr_pkg::PIN_COUNT-1:0] padOut,
	input wire logic [afr_pkg::PIN_COUNT-1:0] padOe,
	input wire logic [afr_pkg::PIN_COUNT-1:0] boardOut,
	input wire logic [afr_pkg::PIN_COUNT-1:0] boardOe,
	output logic [afr_pkg::PIN_COUNT-1:0] padIn
);
	// the chip wins a contention so a routing fault shows on the sampled inputs
	always_comb
	begin
		for (int i = 0; i < afr_pkg::PIN_COUNT; i++)
		begin
			padIn[i] = padOe[i] ? padOut[i] : (boardOe[i] ? boardOut[i] : 1'b1);
		end
	end
endmodule

//--- verification/test_alternate_function_redirect.sv
// self-checking bench for the alternate function redirect pin multiplexer
`timescale 1ns/100ps
module test_alternate_function_redirect;
	localparam int PN = afr_pkg::PIN_COUNT;
	localparam logic [7:0] CFG = afr_pkg::ADDR_CLOCK_PIN_CONFIG;
	localparam logic [7:0] RTE = afr_pkg::ADDR_PORT_ROUTE_SELECT;
	localparam logic [5:0] P60 = afr_pkg::PIN_P6_0;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] sfrAddr = 8'h00;
	logic [3:0] sfrPage = 4'h0;
	logic sfrWrite = 1'b0;
	logic [7:0] sfrWdata = 8'h00;
	logic [7:0] sfrRdata;
	logic [1:0] clockSource = afr_pkg::CLK_SRC_HIGH_RC;
	logic masterClock = 1'b0;
	logic modeBit = 1'b0;
	logic resetPinIn = 1'b0;
	logic pushPull, fastDrive, xtalOut, xtalIn, extClkIn, resetReq;
	logic t0In, rxPin, sclIn, sdaIn;
	logic t0Out = 1'b1;
	logic t0En = 1'b1;
	logic txPin = 1'b0;
	logic txEn = 1'b1;
	logic sclOut = 1'b0;
	logic sclOe = 1'b1;
	logic sdaOut = 1'b0;
	logic sdaOe = 1'b1;
	logic [PN-1:0] gpioOut = 40'hA5_5A_C3_3C_96;
	logic [PN-1:0] gpioOe = '1;
	logic [PN-1:0] boardOut = '0;
	logic [PN-1:0] boardOe = '0;
	logic [PN-1:0] one = {{(PN-1){1'b0}}, 1'b1};
	logic [PN-1:0] padIn, padOut, padOe;
	logic [5:0] t0Pins [4] = '{afr_pkg::PIN_P3_4, afr_pkg::PIN_P4_4, afr_pkg::PIN_P4_6,
		afr_pkg::PIN_P0_5};
	logic [5:0] txPins [2] = '{afr_pkg::PIN_P3_1, afr_pkg::PIN_P4_5};
	logic [5:0] rxPins [2] = '{afr_pkg::PIN_P3_0, afr_pkg::PIN_P4_4};
	logic [5:0] sclPins [4] = '{afr_pkg::PIN_P4_0, afr_pkg::PIN_P6_0, afr_pkg::PIN_P3_1,
		afr_pkg::PIN_P2_2};
	logic [5:0] sdaPins [4] = '{afr_pkg::PIN_P4_1, afr_pkg::PIN_P6_1, afr_pkg::PIN_P3_0,
		afr_pkg::PIN_P2_4};
	int nMismatch = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int n;
	int exp;

	alternate_function_redirect alternate_function_redirect_i (.sys_clk(sys_clk),
		.arst_n(arst_n), .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWrite(sfrWrite),
		.sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .clockSource(clockSource),
		.masterClock(masterClock), .pin6_0_output_mode_bit(modeBit),
		.pin6_0_pushPull(pushPull), .pin6_0_fast_drive(fastDrive), .crystal_output(xtalOut),
		.crystal_input(xtalIn), .external_clock_input(extClkIn), .resetPinIn(resetPinIn),
		.externalResetReq(resetReq), .gpioOut(gpioOut), .gpioOe(gpioOe), .padIn(padIn),
		.padOut(padOut), .padOe(padOe), .timer0Input(t0In), .timer0_clock_out(t0Out),
		.timer0ClockOutEn(t0En), .uart0_receive_pin(rxPin), .uart0_transmit_pin(txPin),
		.uart0TransmitEn(txEn), .twoWireClockIn(sclIn), .twoWireClockOut(sclOut),
		.twoWireClockOe(sclOe), .twoWireDataIn(sdaIn), .twoWireDataOut(sdaOut),
		.twoWireDataOe(sdaOe));

	afr_board_model afr_board_model_i (.padOut(padOut), .padOe(padOe), .boardOut(boardOut),
		.boardOe(boardOe), .padIn(padIn));

	initial forever #50 sys_clk = ~sys_clk;

	// master clock at a quarter of the system clock, well inside the sampling limit
	always
	begin
		repeat (2) @(posedge sys_clk);
		#1 masterClock = ~masterClock;
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			nMismatch++;
			wrapUp();
		end
	end

	task automatic wrapUp();
		$display("checks %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		samplesChecked++;
		if (seen !== want)
		begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic tick(input int cnt);
		repeat (cnt) @(posedge sys_clk);
		#1;
	endtask

	task automatic sfrWr(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] data);
		sfrPage = page;
		sfrAddr = addr;
		sfrWdata = data;
		sfrWrite = 1'b1;
		tick(1);
		sfrWrite = 1'b0;
		tick(2);
	endtask

	task automatic sfrRd(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] e);
		sfrPage = page;
		sfrAddr = addr;
		tick(2);
		check("sfr read", sfrRdata, e);
	endtask

	task automatic pinChk(input string what, input logic [5:0] pin, input logic oe,
		input logic out);
		check(what, {6'h00, padOe[pin], padOut[pin]}, {6'h00, oe, out});
	endtask

	// board drives one pin to lvl and every other pin to the opposite level
	task automatic board(input logic [5:0] pin, input logic lvl);
		gpioOe = '0;
		boardOe = '1;
		boardOut = lvl ? (one << pin) : ~(one << pin);
		tick(2);
	endtask

	task automatic boardOff();
		boardOe = '0;
		gpioOe = '1;
		tick(2);
	endtask

	task automatic countEdges(output int cnt);
		logic prev;
		cnt = 0;
		prev = padOut[P60];
		repeat (64)
		begin
			tick(1);
			if (padOut[P60] && !prev)
				cnt++;
			prev = padOut[P60];
		end
	endtask

	initial
	begin
		tick(3);
		arst_n = 1'b1;
		tick(3);
		sfrRd(4'h0, CFG, afr_pkg::RESET_CLOCK_PIN_CONFIG);
		sfrRd(4'h0, RTE, afr_pkg::RESET_PORT_ROUTE_SELECT);
		pinChk("timer0 default", afr_pkg::PIN_P3_4, 1'b1, 1'b1);
		sfrWr(4'h7, CFG, 8'h1F);
		sfrRd(4'h3, CFG, 8'h1F);
		sfrWr(4'h1, RTE, 8'hFF);
		sfrRd(4'h0, RTE, 8'h00);
		sfrRd(4'h1, RTE, afr_pkg::READ_UNMAPPED);
		sfrWr(4'h0, 8'hA2, 8'h77);
		sfrRd(4'h0, 8'hA2, afr_pkg::READ_UNMAPPED);
		sfrWr(4'h0, RTE, 8'h36);
		sfrRd(4'h0, RTE, 8'h36);
		sfrWr(4'h2, CFG, 8'h20);
		check("fast drive on", {7'h00, fastDrive}, 8'h01);
		sfrWr(4'h2, CFG, 8'h00);
		check("fast drive off", {7'h00, fastDrive}, 8'h00);
		resetPinIn = 1'b1;
		tick(2);
		check("reset pin high", {7'h00, resetReq}, 8'h01);
		resetPinIn = 1'b0;
		tick(2);
		check("reset pin low", {7'h00, resetReq}, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			t0Out = ~gpioOut[t0Pins[c]];
			sfrWr(4'h0, RTE, {c[1:0], 6'h00});
			pinChk("timer0 pin", t0Pins[c], 1'b1, ~gpioOut[t0Pins[c]]);
			if (c > 0)
				pinChk("timer0 old pin", t0Pins[c-1], 1'b1, gpioOut[t0Pins[c-1]]);
			t0En = 1'b0;
			board(t0Pins[c], 1'b0);
			check("timer0 input", {7'h00, t0In}, 8'h00);
			boardOff();
			t0En = 1'b1;
		end
		for (int s = 0; s < 2; s++)
		begin
			txPin = ~gpioOut[txPins[s]];
			sfrWr(4'h0, RTE, {4'h0, s[0], 3'h0});
			pinChk("uart tx pin", txPins[s], 1'b1, ~gpioOut[txPins[s]]);
			pinChk("uart old tx pin", txPins[1-s], 1'b1, gpioOut[txPins[1-s]]);
			board(rxPins[s], 1'b0);
			check("uart rx", {7'h00, rxPin}, 8'h00);
			boardOff();
		end
		// ports all high so a pulled-low two-wire line cannot pass as port data
		gpioOut = '1;
		for (int w = 0; w < 4; w++)
		begin
			sfrWr(4'h0, RTE, {5'h00, w[1:0], 1'b0});
			pinChk("two-wire clock pin", sclPins[w], 1'b1, 1'b0);
			pinChk("two-wire data pin", sdaPins[w], 1'b1, 1'b0);
			sclOe = 1'b0;
			sdaOe = 1'b0;
			board(sclPins[w], 1'b0);
			check("two-wire inputs", {6'h00, sclIn, sdaIn}, 8'h01);
			boardOff();
			sclOe = 1'b1;
			sdaOe = 1'b1;
		end
		gpioOut = 40'hA5_5A_C3_3C_96;
		check("push-pull off", {7'h00, pushPull}, 8'h00);
		modeBit = 1'b1;
		tick(2);
		check("push-pull", {7'h00, pushPull}, 8'h01);
		for (int k = 1; k < 5; k++)
		begin
			clockSource = (k == 4) ? afr_pkg::CLK_SRC_LOW_RC : afr_pkg::CLK_SRC_HIGH_RC;
			sfrWr(4'h9, CFG, {(k == 4) ? afr_pkg::CLOCK_OUT_DIV1 : k[1:0], 6'h00});
			countEdges(n);
			exp = (k == 4) ? 16 : (16 >> (k - 1));
			check("clock out rate", {7'h00, n >= exp - 1 && n <= exp + 1}, 8'h01);
			check("clock out drive", {7'h00, padOe[P60]}, 8'h01);
		end
		sfrWr(4'h0, CFG, 8'h00);
		pinChk("clock pin as port", P60, 1'b1, gpioOut[P60]);
		sfrWr(4'h0, CFG, 8'h40);
		clockSource = afr_pkg::CLK_SRC_CRYSTAL;
		board(afr_pkg::PIN_P6_1, 1'b1);
		check("crystal mode", {4'h0, xtalOut, xtalIn, padOe[P60], extClkIn}, 8'h0C);
		clockSource = afr_pkg::CLK_SRC_EXTERNAL;
		board(P60, 1'b1);
		check("external clock mode", {5'h00, xtalOut, padOe[P60], extClkIn}, 8'h01);
		boardOff();
		arst_n = 1'b0;
		tick(3);
		arst_n = 1'b1;
		tick(3);
		sfrRd(4'h0, RTE, afr_pkg::RESET_PORT_ROUTE_SELECT);
		sfrRd(4'h0, CFG, afr_pkg::RESET_CLOCK_PIN_CONFIG);
		wrapUp();
	end
endmodule
